// [hdl/speakerphone_agc_pair.sv]
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module speakerphone_agc_pair import agc_pkg::*; (
	// clock and reset
	input logic clk,
	input logic rst_b,
	// register bus
	input ahb_req_t ahb,
	output ahb_rsp_t ahb_rsp,
	// speech comparators and detectors
	input logic acoustic_cmp_hit,
	input logic line_cmp_hit,
	input logic [7:0] tx_noise_mag,
	input logic [7:0] rx_noise_mag,
	// voice samples
	input sample_t tx_in,
	input sample_t rx_in,
	output sample_t tx_out,
	output sample_t rx_out,
	output sample_t rx_det,
	// attenuation control
	output logic [7:0] sweep_range,
	output logic dir_tx
);

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		logic rd_pend;
		logic wr_pend;
		logic [11:0] addr;
		logic [31:0] rdata;
		logic [3:0] ctrl;
		logic [7:0] att_base;
		agc_coef_t tx_coef;
		agc_coef_t rx_coef;
		logic dir_tx;
		sample_t det;
		logic [7:0] sweep;
	} regs_t;

	regs_t r_q, r_d;
	logic signed [7:0] tx_gain;
	logic signed [7:0] rx_gain;
	logic signed [9:0] sweep_sum;
	logic addr_take;

	// ************************************************
	// decoding
	// ************************************************
	function automatic reg_sel_t reg_sel(input logic [11:0] a);
		reg_sel_t s;
		unique case (a)
			OFS_CTRL: s = SEL_CTRL;
			OFS_ATT: s = SEL_ATT;
			OFS_TX_LEVEL: s = SEL_TX_LEVEL;
			OFS_TX_RANGE: s = SEL_TX_RANGE;
			OFS_TX_SETTLE: s = SEL_TX_SETTLE;
			OFS_RX_LEVEL: s = SEL_RX_LEVEL;
			OFS_RX_RANGE: s = SEL_RX_RANGE;
			OFS_RX_SETTLE: s = SEL_RX_SETTLE;
			OFS_STATUS: s = SEL_STATUS;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	// word 0 level, 1 range, 2 settle
	function automatic logic [31:0] coef_rd(input agc_coef_t c,
		input logic [1:0] w);
		logic [31:0] v;
		unique case (w)
			2'h0: v = {c.init, c.noise, c.thresh, c.loud};
			2'h1: v = {16'h0000, c.gain_max, c.atten};
			default: v = {4'h0, c.slow, 4'h0, c.fast};
		endcase
		return v;
	endfunction

	function automatic agc_coef_t coef_wr(input agc_coef_t c,
		input logic [1:0] w, input logic [31:0] d);
		agc_coef_t n;
		n = c;
		unique case (w)
			2'h0: begin
				n.init = d[31:24];
				n.noise = d[23:16];
				n.thresh = d[15:8];
				n.loud = d[7:0];
			end
			2'h1: begin
				n.gain_max = d[15:8];
				n.atten = d[7:0];
			end
			default: begin
				n.slow = d[27:16];
				n.fast = d[11:0];
			end
		endcase
		return n;
	endfunction

	// ************************************************
	// gain stages
	// ************************************************
	agc_channel tx_chan (
		.clk(clk),
		.rst_b(rst_b),
		.sp_en(r_q.ctrl[CTRL_SP]),
		.agc_en(r_q.ctrl[CTRL_TX_EN]),
		.freeze(!r_q.dir_tx),
		.coef(r_q.tx_coef),
		.noise_mag(tx_noise_mag),
		.smp_in(tx_in),
		.smp_out(tx_out),
		.gain_eff(tx_gain)
	);

	// own coefficient set for receive
	agc_channel rx_chan (
		.clk(clk),
		.rst_b(rst_b),
		.sp_en(r_q.ctrl[CTRL_SP]),
		.agc_en(r_q.ctrl[CTRL_RX_EN]),
		.freeze(r_q.dir_tx),
		.coef(r_q.rx_coef),
		.noise_mag(rx_noise_mag),
		.smp_in(rx_in),
		.smp_out(rx_out),
		.gain_eff(rx_gain)
	);

	// ************************************************
	// outputs
	// ************************************************
	assign addr_take = ahb.hsel && ahb.htrans == HTRANS_NONSEQ && ahb.hready;
	assign sweep_sum = $signed({2'b00, r_q.att_base})
		+ {{2{tx_gain[7]}}, tx_gain}
		+ {{2{rx_gain[7]}}, rx_gain};
	assign ahb_rsp.hreadyout = !r_q.rd_pend;
	assign ahb_rsp.hresp = 1'b0;
	assign ahb_rsp.hrdata = r_q.rdata;
	assign sweep_range = r_q.sweep;
	assign dir_tx = r_q.dir_tx;
	assign rx_det = r_q.det;

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		r_d = r_q;
		if (ahb.hready) begin
			r_d.rd_pend = addr_take && !ahb.hwrite;
			r_d.wr_pend = addr_take && ahb.hwrite;
			r_d.addr = ahb.haddr;
		end
		// one wait state, read data from a register
		if (r_q.rd_pend) begin
			r_d.rd_pend = 1'b0;
			unique case (reg_sel(r_q.addr))
				SEL_CTRL: r_d.rdata = {28'h000_0000, r_q.ctrl};
				SEL_ATT: r_d.rdata = {24'h00_0000, r_q.att_base};
				SEL_TX_LEVEL: r_d.rdata = coef_rd(r_q.tx_coef, 2'h0);
				SEL_TX_RANGE: r_d.rdata = coef_rd(r_q.tx_coef, 2'h1);
				SEL_TX_SETTLE: r_d.rdata = coef_rd(r_q.tx_coef, 2'h2);
				SEL_RX_LEVEL: r_d.rdata = coef_rd(r_q.rx_coef, 2'h0);
				SEL_RX_RANGE: r_d.rdata = coef_rd(r_q.rx_coef, 2'h1);
				SEL_RX_SETTLE: r_d.rdata = coef_rd(r_q.rx_coef, 2'h2);
				SEL_STATUS: begin
					r_d.rdata = {7'h00, r_q.dir_tx, r_q.sweep,
						rx_gain, tx_gain};
				end
				SEL_NONE: r_d.rdata = 32'h0000_0000;
			endcase
		end
		if (r_q.wr_pend) begin
			unique case (reg_sel(r_q.addr))
				SEL_CTRL: r_d.ctrl = ahb.hwdata[3:0];
				SEL_ATT: r_d.att_base = ahb.hwdata[7:0];
				SEL_TX_LEVEL: begin
					r_d.tx_coef = coef_wr(r_q.tx_coef, 2'h0, ahb.hwdata);
				end
				SEL_TX_RANGE: begin
					r_d.tx_coef = coef_wr(r_q.tx_coef, 2'h1, ahb.hwdata);
				end
				SEL_TX_SETTLE: begin
					r_d.tx_coef = coef_wr(r_q.tx_coef, 2'h2, ahb.hwdata);
				end
				SEL_RX_LEVEL: begin
					r_d.rx_coef = coef_wr(r_q.rx_coef, 2'h0, ahb.hwdata);
				end
				SEL_RX_RANGE: begin
					r_d.rx_coef = coef_wr(r_q.rx_coef, 2'h1, ahb.hwdata);
				end
				SEL_RX_SETTLE: begin
					r_d.rx_coef = coef_wr(r_q.rx_coef, 2'h2, ahb.hwdata);
				end
				SEL_STATUS: r_d.ctrl = r_q.ctrl;
				SEL_NONE: r_d.ctrl = r_q.ctrl;
			endcase
		end
		// direction from the speech comparators
		if (!r_q.dir_tx && acoustic_cmp_hit) begin
			r_d.dir_tx = 1'b1;
		end else if (r_q.dir_tx && line_cmp_hit) begin
			r_d.dir_tx = 1'b0;
		end
		// detector tap ahead of or behind the receive gain
		if (r_q.ctrl[CTRL_TAP]) begin
			r_d.det = rx_in;
		end else begin
			r_d.det = rx_out;
		end
		// sweep follows both gains for constant loop gain
		if (sweep_sum < 0) begin
			r_d.sweep = 8'h00;
		end else if (sweep_sum > 10'sh0ff) begin
			r_d.sweep = 8'hff;
		end else begin
			r_d.sweep = sweep_sum[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			r_q <= '0;
			r_q.ctrl <= CTRL_RST;
			r_q.att_base <= ATT_RST;
			r_q.tx_coef <= COEF_RST;
			r_q.rx_coef <= COEF_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	property p_dir_to_tx;
		@(posedge clk) disable iff (!rst_b)
		!dir_tx && acoustic_cmp_hit |=> dir_tx;
	endproperty
	a_dir_to_tx: assert property (p_dir_to_tx) else $error("no tx switch");

	property p_dir_to_rx;
		@(posedge clk) disable iff (!rst_b)
		dir_tx && line_cmp_hit |=> !dir_tx;
	endproperty
	a_dir_to_rx: assert property (p_dir_to_rx) else $error("no rx switch");

	property p_dir_stable;
		@(posedge clk) disable iff (!rst_b)
		!acoustic_cmp_hit && !line_cmp_hit |=> $stable(dir_tx);
	endproperty
	a_dir_stable: assert property (p_dir_stable) else $error("dir moved");

	property p_sweep;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> sweep_range == ($past(sweep_sum) < 0 ? 8'h00
			: ($past(sweep_sum) > 10'sh0ff ? 8'hff
			: 8'($past(sweep_sum))));
	endproperty
	a_sweep: assert property (p_sweep) else $error("sweep mismatch");

	property p_tap_direct;
		@(posedge clk) disable iff (!rst_b)
		r_q.ctrl[CTRL_TAP] && rx_in.valid
			|=> rx_det.valid && rx_det.data == $past(rx_in.data);
	endproperty
	a_tap_direct: assert property (p_tap_direct) else $error("tap wrong");

	property p_tap_gain;
		@(posedge clk) disable iff (!rst_b)
		!r_q.ctrl[CTRL_TAP] && rx_out.valid
			|=> rx_det.valid && rx_det.data == $past(rx_out.data);
	endproperty
	a_tap_gain: assert property (p_tap_gain) else $error("tap wrong");

	sequence s_rd_status;
		addr_take && !ahb.hwrite && ahb.haddr == OFS_STATUS;
	endsequence

	sequence s_rd_answer;
		!ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout
			&& ahb_rsp.hrdata[15:8] == $past(rx_gain);
	endsequence

	property p_rd_gain;
		@(posedge clk) disable iff (!rst_b)
		s_rd_status |=> s_rd_answer;
	endproperty
	a_rd_gain: assert property (p_rd_gain) else $error("gain read bad");

	sequence s_wr_level;
		addr_take && ahb.hwrite && ahb.haddr == OFS_RX_LEVEL;
	endsequence

	property p_wr_level;
		@(posedge clk) disable iff (!rst_b)
		s_wr_level ##1 ahb_rsp.hreadyout
			|=> r_q.rx_coef.init == $past(ahb.hwdata[31:24])
			&& r_q.rx_coef.thresh == $past(ahb.hwdata[15:8]);
	endproperty
	a_wr_level: assert property (p_wr_level) else $error("write lost");

	property p_sp_off;
		@(posedge clk) disable iff (!rst_b)
		!r_q.ctrl[CTRL_SP] |=> tx_gain == 0 && rx_gain == 0;
	endproperty
	a_sp_off: assert property (p_sp_off) else $error("gain without sp");

	sequence s_rd_take;
		addr_take && !ahb.hwrite;
	endsequence

	property p_rd_wait;
		@(posedge clk) disable iff (!rst_b)
		s_rd_take |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("bad wait");

	sequence s_wr_ctrl;
		addr_take && ahb.hwrite && ahb.haddr == OFS_CTRL;
	endsequence

	property p_wr_ctrl;
		@(posedge clk) disable iff (!rst_b)
		s_wr_ctrl ##1 ahb_rsp.hreadyout
			|=> r_q.ctrl == $past(ahb.hwdata[3:0]);
	endproperty
	a_wr_ctrl: assert property (p_wr_ctrl) else $error("ctrl lost");

	sequence s_wr_att;
		addr_take && ahb.hwrite && ahb.haddr == OFS_ATT;
	endsequence

	property p_wr_att;
		@(posedge clk) disable iff (!rst_b)
		s_wr_att ##1 ahb_rsp.hreadyout
			|=> r_q.att_base == $past(ahb.hwdata[7:0]);
	endproperty
	a_wr_att: assert property (p_wr_att) else $error("att lost");

	sequence s_rx_enable;
		$rose(r_q.ctrl[CTRL_SP] && r_q.ctrl[CTRL_RX_EN]);
	endsequence

	// initial value inside both bounds, no noise excess
	property p_rx_init;
		@(posedge clk) disable iff (!rst_b)
		s_rx_enable ##0 (r_q.rx_coef.init <= 0
			&& r_q.rx_coef.init >= -$signed({1'b0, r_q.rx_coef.atten})
			&& rx_noise_mag >= r_q.rx_coef.noise)
			|=> rx_gain == $past(r_q.rx_coef.init);
	endproperty
	a_rx_init: assert property (p_rx_init) else $error("rx init");

endmodule // speakerphone_agc_pair

// [hdl/agc_pkg.sv]
// Summary of operation
// - tx regulation only with speakerphone enabled
// - compare level against programmable threshold
// - fast constant above, slow below threshold
// - noise above threshold lowers gain equally
// - tx loudness stage follows detector, speakerphone
// - tx loudness stays on with agc off
// - receive direction freezes tx gain
// - tx gain adjusts attenuation sweep range
// - tx starts from initial gain on enable
// - tx gain bounded by attenuation, gain ranges
// - rx agc, loudness only in speakerphone
// - rx attenuates too; limiter at gain_max
// - rx detector tap is selectable
// - transmit direction freezes rx gain
// - rx starts from initial value on enable
// - rx gain adjusts attenuation sweep range
// - rx momentary gain readable, coefficients rewritable
// - rx uses own threshold, constants, noise
// - comparators steer the direction state
package agc_pkg;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_ATT = 12'h004;
	localparam logic [11:0] OFS_TX_LEVEL = 12'h008;
	localparam logic [11:0] OFS_TX_RANGE = 12'h00c;
	localparam logic [11:0] OFS_TX_SETTLE = 12'h010;
	localparam logic [11:0] OFS_RX_LEVEL = 12'h014;
	localparam logic [11:0] OFS_RX_RANGE = 12'h018;
	localparam logic [11:0] OFS_RX_SETTLE = 12'h01c;
	localparam logic [11:0] OFS_STATUS = 12'h020;
	localparam int CTRL_SP = 0;
	localparam int CTRL_TX_EN = 1;
	localparam int CTRL_RX_EN = 2;
	localparam int CTRL_TAP = 3;
	localparam int STATUS_DIR = 24;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [7:0] ATT_RST = 8'h00;
	localparam logic [11:0] SETTLE_RST = 12'h001;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ************************************************
	// signal processing constants
	// ************************************************
	localparam int SAMPLE_KHZ = 8;
	localparam int DB_PER_BIT = 6;
	localparam logic [7:0] LVL_SILENT = 8'h5a;
	localparam int FRAC_SHIFT = 14;

	typedef enum logic [3:0] {
		SEL_CTRL, SEL_ATT, SEL_TX_LEVEL, SEL_TX_RANGE, SEL_TX_SETTLE,
		SEL_RX_LEVEL, SEL_RX_RANGE, SEL_RX_SETTLE, SEL_STATUS, SEL_NONE
	} reg_sel_t;

	typedef struct packed {
		logic signed [7:0] init;
		logic [7:0] noise;
		logic [7:0] thresh;
		logic signed [7:0] loud;
		logic [7:0] gain_max;
		logic [7:0] atten;
		logic [11:0] slow;
		logic [11:0] fast;
	} agc_coef_t;

	localparam agc_coef_t COEF_RST = '{init: 8'h00, noise: 8'h00,
		thresh: 8'h00, loud: 8'h00, gain_max: 8'h00, atten: 8'h00,
		slow: SETTLE_RST, fast: SETTLE_RST};

	typedef struct packed {
		logic valid;
		logic signed [15:0] data;
	} sample_t;

	typedef struct packed {
		logic hsel;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [11:0] haddr;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_t;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} ahb_rsp_t;

endpackage

// [hdl/agc_channel.sv]
`timescale 1ns/1ps
module agc_channel import agc_pkg::*; (
	// clock and reset
	input logic clk,
	input logic rst_b,
	// mode
	input logic sp_en,
	input logic agc_en,
	input logic freeze,
	input agc_coef_t coef,
	input logic [7:0] noise_mag,
	// samples
	input sample_t smp_in,
	output sample_t smp_out,
	output logic signed [7:0] gain_eff
);

	typedef struct packed {
		logic was_on;
		logic signed [7:0] gain;
		logic signed [7:0] eff;
		logic [14:0] cnt;
		sample_t out;
	} chan_t;

	chan_t s_q, s_d;
	logic on, above;
	logic [7:0] excess;
	logic [14:0] limit;
	logic signed [9:0] upper, lower, g10, total;

	// magnitude below full scale, in dB
	function automatic logic [7:0] level_mag(input logic signed [15:0] x);
		logic [15:0] a;
		logic [7:0] m;
		a = x[15] ? 16'(-x) : x;
		m = LVL_SILENT;
		for (int i = 0; i < 15; i++) begin
			if (a[i]) m = 8'((14 - i) * DB_PER_BIT);
		end
		if (a[15]) m = 8'h00;
		return m;
	endfunction

	function automatic logic signed [7:0] clamp8(input logic signed [9:0] v,
		input logic signed [9:0] hi, input logic signed [9:0] lo);
		logic signed [9:0] r;
		r = v;
		if (r < lo) r = lo;
		if (r > hi) r = hi;
		return 8'(r);
	endfunction

	// gain in dB applied as shift plus fractional factor
	function automatic logic signed [15:0] scale(input logic signed [15:0] x,
		input logic signed [9:0] db);
		logic signed [10:0] t;
		logic signed [10:0] sh;
		logic [15:0] f;
		logic signed [47:0] p;
		t = 11'(db) + 11'sh03c;
		sh = 11'(t / 6) - 11'sh00a;
		unique case (3'(t % 6))
			3'h0: f = 16'h4000;
			3'h1: f = 16'h47cf;
			3'h2: f = 16'h5092;
			3'h3: f = 16'h5a67;
			3'h4: f = 16'h656f;
			default: f = 16'h71cf;
		endcase
		p = 48'(x) * $signed({32'h0000_0000, f});
		if (sh >= 0) p = p <<< 4'(sh);
		else p = p >>> 4'(-sh);
		p = p >>> FRAC_SHIFT;
		if (p > 48'sh0000_0000_7fff) return 16'sh7fff;
		if (p < -48'sh0000_0000_8000) return 16'sh8000;
		return 16'(p);
	endfunction

	assign on = sp_en & agc_en;
	assign above = level_mag(smp_in.data) < coef.thresh;
	assign excess = (noise_mag < coef.noise) ? 8'(coef.noise - noise_mag)
		: 8'h00;
	assign upper = $signed({2'b00, coef.gain_max})
		- $signed({2'b00, excess});
	assign lower = -$signed({2'b00, coef.atten});
	assign limit = 15'((above ? coef.fast : coef.slow) * SAMPLE_KHZ);
	assign g10 = {{2{s_q.gain[7]}}, s_q.gain};
	assign total = (on ? g10 : 10'sh000)
		+ (sp_en ? {{2{coef.loud[7]}}, coef.loud} : 10'sh000);
	assign smp_out = s_q.out;
	assign gain_eff = s_q.eff;

	always_comb begin
		s_d = s_q;
		s_d.was_on = on;
		s_d.out.valid = smp_in.valid;
		if (smp_in.valid) begin
			s_d.out.data = sp_en ? scale(smp_in.data, total) : smp_in.data;
		end
		if (on && !s_q.was_on) begin
			s_d.gain = clamp8({{2{coef.init[7]}}, coef.init},
				upper, lower);
			s_d.cnt = '0;
		end else if (on && !freeze && smp_in.valid) begin
			if (s_q.cnt + 15'h0001 >= limit) begin
				s_d.cnt = '0;
				s_d.gain = clamp8(g10 + (above ? -10'sh001 : 10'sh001),
					upper, lower);
			end else begin
				s_d.cnt = s_q.cnt + 15'h0001;
			end
		end
		s_d.eff = on ? s_d.gain : 8'sh00;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) s_q <= '0;
		else s_q <= s_d;
	end

	property p_bypass;
		@(posedge clk) disable iff (!rst_b)
		!sp_en && smp_in.valid |=> smp_out.valid
			&& smp_out.data == $past(smp_in.data);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass altered");

	property p_init;
		@(posedge clk) disable iff (!rst_b)
		on && !s_q.was_on && coef.init <= coef.gain_max
			&& $signed(coef.init) >= 0 && excess == 0
			|=> s_q.gain == $past(coef.init);
	endproperty
	a_init: assert property (p_init) else $error("initial gain missed");

	property p_hold;
		@(posedge clk) disable iff (!rst_b)
		on && s_q.was_on && freeze |=> s_q.gain == $past(s_q.gain);
	endproperty
	a_hold: assert property (p_hold) else $error("gain moved frozen");

	property p_step;
		@(posedge clk) disable iff (!rst_b)
		on && s_q.was_on && s_q.gain > lower && s_q.gain < upper
			|=> s_q.gain - $past(s_q.gain) <= 1
			&& $past(s_q.gain) - s_q.gain <= 1;
	endproperty
	a_step: assert property (p_step) else $error("gain jumped");

endmodule // agc_channel

// [verification/agc_far_end.sv]
`timescale 1ns/1ps
module agc_far_end import agc_pkg::*; (
	// clock
	input logic clk,
	// from the block
	input sample_t tx_out,
	input sample_t rx_out,
	input sample_t rx_det,
	// to the block
	output sample_t tx_in,
	output sample_t rx_in,
	output logic acoustic_cmp_hit,
	output logic line_cmp_hit,
	output logic [7:0] tx_noise_mag,
	output logic [7:0] rx_noise_mag
);
	initial begin
		tx_in = '0;
		rx_in = '0;
		acoustic_cmp_hit = 1'b0;
		line_cmp_hit = 1'b0;
		tx_noise_mag = 8'hff;
		rx_noise_mag = 8'hff;
	end

	// ************************************************
	// sample path
	// ************************************************
	// one sample; data goes stale-inverted once valid drops
	task send(input logic rx, input logic [15:0] d, output sample_t o,
		output sample_t d1, output sample_t d2);
		@(posedge clk);
		if (rx) rx_in <= '{1'b1, d};
		else tx_in <= '{1'b1, d};
		@(posedge clk);
		rx_in <= '{1'b0, ~rx_in.data};
		tx_in <= '{1'b0, ~tx_in.data};
		#1;
		o = rx ? rx_out : tx_out;
		d1 = rx_det;
		@(posedge clk);
		#1;
		d2 = rx_det;
	endtask

	task set_noise(input logic [7:0] t);
		@(posedge clk);
		tx_noise_mag <= t;
		rx_noise_mag <= t;
	endtask

	// ************************************************
	// speech comparators
	// ************************************************
	task steer(input logic to_tx);
		@(posedge clk);
		if (to_tx) acoustic_cmp_hit <= 1'b1;
		else line_cmp_hit <= 1'b1;
		@(posedge clk);
		acoustic_cmp_hit <= 1'b0;
		line_cmp_hit <= 1'b0;
		// new direction settles after the edge
		#1;
	endtask
endmodule // agc_far_end

// [verification/speakerphone_agc_pair_test.sv]
`timescale 1ns/1ps
module speakerphone_agc_pair_test import agc_pkg::*; ();
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	ahb_req_t req = '0;
	ahb_req_t ahb_in;
	ahb_rsp_t ahb_rsp;
	sample_t tx_in, rx_in, tx_out, rx_out, rx_det, o, d1, d2;
	logic acoustic_cmp_hit, line_cmp_hit, dir_tx;
	logic [7:0] tx_noise_mag, rx_noise_mag, sweep_range;
	logic [31:0] rd;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	int seed = 32'h1a7c_d10d;
	int ti, tg, tn, ri, rg, ra, et, er, sw;

	always #25 clk = ~clk;
	always_comb begin
		ahb_in = req;
		ahb_in.hready = ahb_rsp.hreadyout;
	end

	speakerphone_agc_pair u_dut (.clk(clk), .rst_b(rst_b), .ahb(ahb_in),
		.ahb_rsp(ahb_rsp), .acoustic_cmp_hit(acoustic_cmp_hit),
		.line_cmp_hit(line_cmp_hit), .tx_noise_mag(tx_noise_mag),
		.rx_noise_mag(rx_noise_mag), .tx_in(tx_in), .rx_in(rx_in),
		.tx_out(tx_out), .rx_out(rx_out), .rx_det(rx_det),
		.sweep_range(sweep_range), .dir_tx(dir_tx));

	agc_far_end u_far (.clk(clk), .tx_out(tx_out), .rx_out(rx_out),
		.rx_det(rx_det), .tx_in(tx_in), .rx_in(rx_in),
		.acoustic_cmp_hit(acoustic_cmp_hit), .line_cmp_hit(line_cmp_hit),
		.tx_noise_mag(tx_noise_mag), .rx_noise_mag(rx_noise_mag));

	// ************************************************
	// helpers
	// ************************************************
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// single word transfer, held until hready is sampled high
	task bus(input logic is_wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		@(posedge clk);
		req.hsel <= 1'b1;
		req.htrans <= HTRANS_NONSEQ;
		req.hwrite <= is_wr;
		req.hsize <= 3'h2;
		req.haddr <= a;
		do @(posedge clk); while (ahb_rsp.hreadyout !== 1'b1);
		req.hsel <= 1'b0;
		req.htrans <= 2'h0;
		req.hwdata <= wd;
		do @(posedge clk); while (ahb_rsp.hreadyout !== 1'b1);
		q = ahb_rsp.hrdata;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, rd);
		chk(rd, e);
		chk({31'h0000_0000, ahb_rsp.hresp}, 32'h0000_0000);
	endtask

	// one byte of the status word
	task gchk(input int sh, input logic [7:0] e);
		bus(1'b0, OFS_STATUS, 32'h0000_0000, rd);
		chk(rd[sh +: 8], e);
	endtask

	task burst(input logic rx, input logic [15:0] d, input int n);
		repeat (n) u_far.send(rx, d, o, d1, d2);
	endtask

	function automatic int clampi(input int v, input int lo, input int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction

	// ************************************************
	// scenarios
	// ************************************************
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		rdchk(OFS_CTRL, 32'h0000_0000);
		rdchk(OFS_TX_SETTLE, 32'h0001_0001);
		rdchk(OFS_RX_SETTLE, 32'h0001_0001);
		wr(12'h0fc, 32'hffff_ffff);
		rdchk(12'h0fc, 32'h0000_0000);
		wr(OFS_STATUS, 32'hffff_ffff);
		rdchk(OFS_STATUS, 32'h0000_0000);
		$display("test reset done");

		// agc bits set but speakerphone off
		wr(OFS_CTRL, 32'h0000_0006);
		for (int i = 0; i < 8; i++) begin
			logic [15:0] d;
			d = 16'($random(seed));
			u_far.send(i[0], d, o, d1, d2);
			chk({15'h0, o.valid, o.data}, {16'h0001, d});
		end
		rdchk(OFS_STATUS, 32'h0000_0000);
		$display("test bypass done");

		// loudness stages with agc off, detector tap both ways
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_TX_LEVEL, 32'h0000_0006);
		wr(OFS_RX_LEVEL, 32'h0000_00fa);
		u_far.send(1'b0, 16'h0100, o, d1, d2);
		chk(o.data, 16'h0200);
		u_far.send(1'b1, 16'h0100, o, d1, d2);
		chk(o.data, 16'h0080);
		chk(d2.data, 16'h0080);
		wr(OFS_CTRL, 32'h0000_0009);
		u_far.send(1'b1, 16'h0100, o, d1, d2);
		chk(d1.data, 16'h0100);
		$display("test loudness done");

		// random initial gains, ranges and noise
		wr(OFS_ATT, 32'h0000_001e);
		for (int i = 0; i < 6; i++) begin
			ti = {$random(seed)} % 19;
			tg = {$random(seed)} % 19;
			tn = 20 + {$random(seed)} % 41;
			ri = {$random(seed)} % 66 - 47;
			rg = {$random(seed)} % 19;
			ra = 20 + {$random(seed)} % 28;
			u_far.set_noise(tn[7:0]);
			wr(OFS_TX_LEVEL, {ti[7:0], 8'd40, 8'd20, 8'h00});
			wr(OFS_TX_RANGE, {16'h0000, tg[7:0], 8'd47});
			wr(OFS_RX_LEVEL, {ri[7:0], 8'd40, 16'h1400});
			wr(OFS_RX_RANGE, {16'h0000, rg[7:0], ra[7:0]});
			wr(OFS_CTRL, 32'h0000_0001);
			wr(OFS_CTRL, 32'h0000_0007);
			et = clampi(ti, -47, tg - (tn < 40 ? 40 - tn : 0));
			er = clampi(ri, -ra, rg - (tn < 40 ? 40 - tn : 0));
			sw = clampi(30 + et + er, 0, 255);
			rdchk(OFS_STATUS,
				{8'h00, sw[7:0], er[7:0], et[7:0]});
			chk(sweep_range, sw[7:0]);
		end
		$display("test initial gain done");

		// regulation, freezing and direction
		u_far.set_noise(8'hff);
		wr(OFS_TX_LEVEL, 32'h0600_1400);
		wr(OFS_TX_RANGE, 32'h0000_122f);
		wr(OFS_RX_LEVEL, 32'h0000_1400);
		wr(OFS_RX_RANGE, 32'h0000_002f);
		wr(OFS_TX_SETTLE, 32'h0002_0001);
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0003);
		burst(1'b0, 16'h7000, 16);
		gchk(0, 8'h06);
		u_far.steer(1'b1);
		chk(dir_tx, 1'b1);
		gchk(24, 8'h01);
		burst(1'b0, 16'h7000, 8);
		gchk(0, 8'h05);
		burst(1'b0, 16'h0004, 8);
		gchk(0, 8'h05);
		burst(1'b0, 16'h0004, 8);
		gchk(0, 8'h06);
		wr(OFS_CTRL, 32'h0000_0007);
		burst(1'b1, 16'h7000, 16);
		gchk(8, 8'h00);
		u_far.steer(1'b0);
		chk(dir_tx, 1'b0);
		burst(1'b1, 16'h7000, 8);
		gchk(8, 8'hff);
		gchk(0, 8'h06);
		$display("test regulation done");
		end_of_test;
	end
endmodule // speakerphone_agc_pair_test
